// file: rtl/hbi_defs.vh
// Constants for the host bus interface with interrupt hierarchy.
// Operation
// - Program through an 8-bit data port; decode 8-bit register address inside.
// - Latch-enable held high selects chip select, read/not-write, data strobe bus.
// - Latch-enable held low selects non-multiplexed bus with separate read, write strobes.
// - Any edge on latch-enable after the start-up count selects multiplexed address/data mode.
// - Multiplexed mode stays until hardware reset; nothing else leaves it.
// - Multiplexed mode captures address from data lines before the access.
// - Address-mode select low: bus address selects the register directly.
// - Address-mode select high: only address bit zero decoded, pointer or data window.
// - Host writes pointer first; data window then reaches the pointed register.
// - Indirect mode ignores address bits above zero; system ties them defined.
// - All registers 8 bits; two independent B-channel files plus D-channel, others.
// - After reset interrupt transfer; DMA only once software sets channel DMA bit.
// - DMA serves B-channel data only; D-channel always host driven.
// - Terminal mode: channels choose DMA freely; line modes: only channel B.
// - One active-low wire-OR interrupt output, present in every mode.
// - Active-high interrupt copy only in terminal mode with second auxiliary pin output.
// - Top status holds two direct indications plus B and D summary bits.
// - Every source has a mask bit; a masked source never drives the request.
// - D-channel sources: pool, message, overflow, underrun, timers, C/I, sync events.
// - Top status carries two external interrupt bits and two D-channel summaries.
`ifndef HBI_DEFS_VH
`define HBI_DEFS_VH
`define HBI_W 8
`define HBI_SYNC_W 26
`define HBI_START_CNT 2'h3
`define HBI_A_CTRL 8'h40
`define HBI_A_TOP_ST 8'h41
`define HBI_A_TOP_MSK 8'h42
`define HBI_A_D_ST 8'h43
`define HBI_A_D_MSK 8'h44
`define HBI_A_DX_ST 8'h45
`define HBI_A_DX_MSK 8'h46
`define HBI_A_BA_ST 8'h47
`define HBI_A_BA_MSK 8'h48
`define HBI_A_BAX_ST 8'h49
`define HBI_A_BAX_MSK 8'h4A
`define HBI_A_BB_ST 8'h4B
`define HBI_A_BB_MSK 8'h4C
`define HBI_A_BBX_ST 8'h4D
`define HBI_A_BBX_MSK 8'h4E
`define HBI_MSK_RST 8'h00
`define HBI_CTRL_RST 8'h00
`define HBI_CTRL_DMA_A 0
`define HBI_CTRL_DMA_B 1
`define HBI_CTRL_SECOND_AUXILIARY_PIN_OUT 2
`define HBI_TOP_EXT0 0
`define HBI_TOP_EXT1 1
`define HBI_TOP_DSUM 2
`define HBI_TOP_DXSUM 3
`define HBI_TOP_BASUM 4
`define HBI_TOP_BAXSUM 5
`define HBI_TOP_BBSUM 6
`define HBI_TOP_BBXSUM 7
`define HBI_BUS_MOTO 2'h0
`define HBI_BUS_SEP 2'h1
`define HBI_BUS_MUX 2'h2
`endif

// file: rtl/hbi_regmem.v
// General register storage with registered read data.
`default_nettype none
module hbi_regmem (
  input wire i_clock,
  input wire i_we,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata
);
  // Storage carries no reset so it maps onto plain memory.
  reg [7:0] mem [0:255];
  always @(posedge i_clock) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule
`default_nettype wire

// file: rtl/hbi_sync.v
// Two-stage synchroniser for asynchronous pin inputs.
`default_nettype none
module hbi_sync #(
  parameter W = 1
) (
  input wire i_clock,
  input wire i_arst_n,
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync
);
  reg [W-1:0] meta_q;
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule
`default_nettype wire

// file: rtl/hbi_top.v
// Host bus interface: bus type detection, addressing and interrupt tree.
`include "hbi_defs.vh"
`default_nettype none
module hbi_top (
  input wire i_clock,
  input wire i_arst_n,
  input wire i_ale,
  input wire i_cs_n,
  input wire i_rw,
  input wire i_ds_n,
  input wire i_wr_n,
  input wire i_rd_n,
  input wire i_address_mode_select,
  input wire i_terminal_mode,
  input wire [7:0] i_addr,
  input wire [7:0] i_data,
  input wire [1:0] i_external_irq_inputs,
  input wire [7:0] i_dchan_events,
  input wire [3:0] i_dchan_ext_events,
  input wire [2:0] i_bchan_a_events,
  input wire [3:0] i_bchan_a_ext_events,
  input wire [2:0] i_bchan_b_events,
  input wire [3:0] i_bchan_b_ext_events,
  output reg [7:0] o_data,
  output reg o_data_oe,
  output reg o_irq_n_out,
  output reg o_irq_n_oe,
  output reg o_second_auxiliary_pin_out,
  output reg o_second_auxiliary_pin_oe,
  output reg o_dma_enable_a,
  output reg o_dma_enable_b,
  output reg [1:0] o_bus_type
);
  localparam ST_IDLE = 2'h0;
  localparam ST_READ = 2'h1;
  localparam ST_WRITE = 2'h2;

  function [7:0] upd;
    input [7:0] st;
    input [7:0] ev;
    input clr;
    begin
      upd = (st & ~{8{clr}}) | ev;
    end
  endfunction

  function [7:0] target;
    input address_mode_select;
    input [7:0] a;
    input [7:0] ptr;
    begin
      if (address_mode_select) begin
        target = ptr;
      end else begin
        target = a;
      end
    end
  endfunction

  wire [`HBI_SYNC_W-1:0] sync_v;
  hbi_sync #(.W(`HBI_SYNC_W)) u_sync (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_async({i_ale, i_cs_n, i_rw, i_ds_n, i_wr_n, i_rd_n,
              i_address_mode_select, i_terminal_mode, i_addr, i_data,
              i_external_irq_inputs}),
    .o_sync(sync_v)
  );
  wire ale_s = sync_v[25];
  wire cs_s = ~sync_v[24];
  wire rw_s = sync_v[23];
  wire ds_s = ~sync_v[22];
  wire wr_s = ~sync_v[21];
  wire rd_s = ~sync_v[20];
  wire address_mode_select_s = sync_v[19];
  wire te_s = sync_v[18];
  wire [7:0] addr_s = sync_v[17:10];
  wire [7:0] data_s = sync_v[9:2];
  wire [1:0] ext_s = sync_v[1:0];

  reg [1:0] start_q;
  reg started_q;
  reg ale_prev_q;
  reg moto_q;
  reg mux_q;
  reg [7:0] alat_q;
  reg [1:0] state_q;
  reg [7:0] acc_addr_q;
  reg acc_ptr_q;
  reg [7:0] wdat_q;
  reg [7:0] ptr_q;
  reg [7:0] rd_int_q;
  reg rd_is_int_q;
  reg [7:0] ctrl_q;
  reg [1:0] ext_q;
  reg [1:0] ext_prev_q;
  reg [7:0] top_msk_q;
  reg [7:0] d_st_q;
  reg [7:0] d_msk_q;
  reg [7:0] dx_st_q;
  reg [7:0] dx_msk_q;
  reg [7:0] ba_st_q;
  reg [7:0] ba_msk_q;
  reg [7:0] bax_st_q;
  reg [7:0] bax_msk_q;
  reg [7:0] bb_st_q;
  reg [7:0] bb_msk_q;
  reg [7:0] bbx_st_q;
  reg [7:0] bbx_msk_q;
  wire [7:0] mem_rdata;

  // The bus type is only judged once the synchroniser holds real pin levels.
  wire ale_edge = started_q & (ale_s != ale_prev_q);
  wire use_moto = moto_q & ~mux_q;
  wire rd_act = cs_s & (use_moto ? (ds_s & rw_s) : rd_s);
  wire wr_act = cs_s & (use_moto ? (ds_s & ~rw_s) : wr_s);
  // Multiplexed cycles take the latched address, others the address pins.
  wire [7:0] bus_a = mux_q ? alat_q : addr_s;
  wire is_ptr = address_mode_select_s & ~bus_a[0];
  wire [7:0] tgt = target(address_mode_select_s, bus_a, ptr_q);
  wire rd_start = (state_q == ST_IDLE) & rd_act & started_q;
  wire wr_start = (state_q == ST_IDLE) & ~rd_act & wr_act & started_q;
  wire commit = (state_q == ST_WRITE) & ~wr_act;
  wire mem_we = commit & ~acc_ptr_q;

  // Reading a status register clears it (top status: only its external bits); a new event in that cycle survives.
  wire clr_top = rd_start & ~is_ptr & (tgt == `HBI_A_TOP_ST);
  wire clr_d = rd_start & ~is_ptr & (tgt == `HBI_A_D_ST);
  wire clr_dx = rd_start & ~is_ptr & (tgt == `HBI_A_DX_ST);
  wire clr_ba = rd_start & ~is_ptr & (tgt == `HBI_A_BA_ST);
  wire clr_bax = rd_start & ~is_ptr & (tgt == `HBI_A_BAX_ST);
  wire clr_bb = rd_start & ~is_ptr & (tgt == `HBI_A_BB_ST);
  wire clr_bbx = rd_start & ~is_ptr & (tgt == `HBI_A_BBX_ST);

  wire [7:0] top_st;
  assign top_st[`HBI_TOP_EXT0] = ext_q[0];
  assign top_st[`HBI_TOP_EXT1] = ext_q[1];
  assign top_st[`HBI_TOP_DSUM] = |(d_st_q & ~d_msk_q);
  assign top_st[`HBI_TOP_DXSUM] = |(dx_st_q & ~dx_msk_q);
  assign top_st[`HBI_TOP_BASUM] = |(ba_st_q & ~ba_msk_q);
  assign top_st[`HBI_TOP_BAXSUM] = |(bax_st_q & ~bax_msk_q);
  assign top_st[`HBI_TOP_BBSUM] = |(bb_st_q & ~bb_msk_q);
  assign top_st[`HBI_TOP_BBXSUM] = |(bbx_st_q & ~bbx_msk_q);
  wire irq_any = |(top_st & ~top_msk_q);

  reg [7:0] int_rd;
  reg int_hit;
  always @* begin
    int_rd = 8'h00;
    int_hit = 1'b1;
    case (tgt)
      `HBI_A_CTRL: int_rd = ctrl_q;
      `HBI_A_TOP_ST: int_rd = top_st;
      `HBI_A_TOP_MSK: int_rd = top_msk_q;
      `HBI_A_D_ST: int_rd = d_st_q;
      `HBI_A_D_MSK: int_rd = d_msk_q;
      `HBI_A_DX_ST: int_rd = dx_st_q;
      `HBI_A_DX_MSK: int_rd = dx_msk_q;
      `HBI_A_BA_ST: int_rd = ba_st_q;
      `HBI_A_BA_MSK: int_rd = ba_msk_q;
      `HBI_A_BAX_ST: int_rd = bax_st_q;
      `HBI_A_BAX_MSK: int_rd = bax_msk_q;
      `HBI_A_BB_ST: int_rd = bb_st_q;
      `HBI_A_BB_MSK: int_rd = bb_msk_q;
      `HBI_A_BBX_ST: int_rd = bbx_st_q;
      `HBI_A_BBX_MSK: int_rd = bbx_msk_q;
      default: int_hit = 1'b0;
    endcase
    // The pointer register is write-only and reads as zero.
    if (is_ptr) begin
      int_rd = 8'h00;
      int_hit = 1'b1;
    end
  end

  hbi_regmem u_mem (
    .i_clock(i_clock),
    .i_we(mem_we),
    .i_addr(acc_addr_q),
    .i_wdata(wdat_q),
    .o_rdata(mem_rdata)
  );

  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      start_q <= 2'h0;
      started_q <= 1'b0;
      ale_prev_q <= 1'b0;
      moto_q <= 1'b0;
      mux_q <= 1'b0;
      alat_q <= 8'h00;
      o_bus_type <= `HBI_BUS_SEP;
    end else begin
      ale_prev_q <= ale_s;
      if (!started_q) begin
        start_q <= start_q + 2'h1;
        if (start_q == `HBI_START_CNT) begin
          started_q <= 1'b1;
          moto_q <= ale_s;
        end
      end
      // Once set, nothing but the reset clears the multiplexed flag.
      if (ale_edge) begin
        mux_q <= 1'b1;
      end
      if (ale_s) begin
        alat_q <= data_s;
      end
      if (mux_q | ale_edge) begin
        o_bus_type <= `HBI_BUS_MUX;
      end else if (started_q) begin
        o_bus_type <= moto_q ? `HBI_BUS_MOTO : `HBI_BUS_SEP;
      end
    end
  end

  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= ST_IDLE;
      acc_addr_q <= 8'h00;
      acc_ptr_q <= 1'b0;
      wdat_q <= 8'h00;
      ptr_q <= 8'h00;
      rd_int_q <= 8'h00;
      rd_is_int_q <= 1'b0;
      o_data <= 8'h00;
      o_data_oe <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          o_data_oe <= 1'b0;
          if (rd_start) begin
            state_q <= ST_READ;
            acc_addr_q <= tgt;
            acc_ptr_q <= is_ptr;
            rd_int_q <= int_rd;
            rd_is_int_q <= int_hit;
          end else if (wr_start) begin
            state_q <= ST_WRITE;
            acc_addr_q <= tgt;
            acc_ptr_q <= is_ptr;
          end
        end
        ST_READ: begin
          o_data <= rd_is_int_q ? rd_int_q : mem_rdata;
          o_data_oe <= rd_act;
          if (!rd_act) begin
            state_q <= ST_IDLE;
          end
        end
        ST_WRITE: begin
          o_data_oe <= 1'b0;
          if (wr_act) begin
            wdat_q <= data_s;
          end else begin
            state_q <= ST_IDLE;
            if (acc_ptr_q) begin
              ptr_q <= wdat_q;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
          o_data_oe <= 1'b0;
        end
      endcase
    end
  end

  // Internal control and mask registers shadow the memory on writes.
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_q <= `HBI_CTRL_RST;
      top_msk_q <= `HBI_MSK_RST;
      d_msk_q <= `HBI_MSK_RST;
      dx_msk_q <= `HBI_MSK_RST;
      ba_msk_q <= `HBI_MSK_RST;
      bax_msk_q <= `HBI_MSK_RST;
      bb_msk_q <= `HBI_MSK_RST;
      bbx_msk_q <= `HBI_MSK_RST;
    end else if (mem_we) begin
      case (acc_addr_q)
        `HBI_A_CTRL: ctrl_q <= wdat_q;
        `HBI_A_TOP_MSK: top_msk_q <= wdat_q;
        `HBI_A_D_MSK: d_msk_q <= wdat_q;
        `HBI_A_DX_MSK: dx_msk_q <= wdat_q;
        `HBI_A_BA_MSK: ba_msk_q <= wdat_q;
        `HBI_A_BAX_MSK: bax_msk_q <= wdat_q;
        `HBI_A_BB_MSK: bb_msk_q <= wdat_q;
        `HBI_A_BBX_MSK: bbx_msk_q <= wdat_q;
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ext_q <= 2'h0;
      ext_prev_q <= 2'h0;
      d_st_q <= 8'h00;
      dx_st_q <= 8'h00;
      ba_st_q <= 8'h00;
      bax_st_q <= 8'h00;
      bb_st_q <= 8'h00;
      bbx_st_q <= 8'h00;
    end else begin
      ext_prev_q <= ext_s;
      ext_q <= (ext_q & ~{2{clr_top}}) | (ext_s & ~ext_prev_q);
      d_st_q <= upd(d_st_q, i_dchan_events, clr_d);
      dx_st_q <= upd(dx_st_q, {4'h0, i_dchan_ext_events}, clr_dx);
      ba_st_q <= upd(ba_st_q, {5'h00, i_bchan_a_events}, clr_ba);
      bax_st_q <= upd(bax_st_q, {4'h0, i_bchan_a_ext_events}, clr_bax);
      bb_st_q <= upd(bb_st_q, {5'h00, i_bchan_b_events}, clr_bb);
      bbx_st_q <= upd(bbx_st_q, {4'h0, i_bchan_b_ext_events}, clr_bbx);
    end
  end

  // The low-active pin only ever pulls down so it can share a pull-up.
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_irq_n_out <= 1'b0;
      o_irq_n_oe <= 1'b0;
      o_second_auxiliary_pin_out <= 1'b0;
      o_second_auxiliary_pin_oe <= 1'b0;
      o_dma_enable_a <= 1'b0;
      o_dma_enable_b <= 1'b0;
    end else begin
      o_irq_n_out <= 1'b0;
      o_irq_n_oe <= irq_any;
      o_second_auxiliary_pin_oe <= te_s & ctrl_q[`HBI_CTRL_SECOND_AUXILIARY_PIN_OUT];
      o_second_auxiliary_pin_out <= te_s & ctrl_q[`HBI_CTRL_SECOND_AUXILIARY_PIN_OUT] &
                                    irq_any;
      // Line modes keep channel A on host transfers whatever is stored.
      o_dma_enable_a <= ctrl_q[`HBI_CTRL_DMA_A] & te_s;
      o_dma_enable_b <= ctrl_q[`HBI_CTRL_DMA_B];
    end
  end
endmodule
`default_nettype wire

// file: verification/hbi_host.sv
// Host processor model that runs register cycles on the device pins.
`default_nettype none
module hbi_host (
  input wire logic i_clock,
  input wire logic [7:0] i_rdata,
  output var logic o_ale,
  output var logic o_cs_n,
  output var logic o_rw,
  output var logic o_ds_n,
  output var logic o_wr_n,
  output var logic o_rd_n,
  output var logic o_address_mode_select,
  output var logic [7:0] o_addr,
  output var logic [7:0] o_data,
  output var logic o_data_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] sel;
  initial begin
    sel = 2'h0;
    o_ale = 1'b1;
    o_cs_n = 1'b1;
    o_rw = 1'b1;
    o_ds_n = 1'b1;
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
    o_address_mode_select = 1'b0;
    o_addr = 8'hFF;
    o_data = 8'h00;
    o_data_oe = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic mode(input logic [1:0] m, input logic ind);
    sel = m;
    o_address_mode_select = ind;
    // Mux mode leaves the pin alone; the first access makes its edge.
    if (m != 2'h2) begin
      o_ale = (m == 2'h0);
    end
  endtask
  // Strobe held 7 cycles and data 4 past release: no synchroniser misses.
  task automatic cyc(input logic rd, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    o_addr = (sel == 2'h2) ? 8'hFF : a;
    if (sel == 2'h2) begin
      o_data = a;
      o_data_oe = 1'b1;
      o_ale = 1'b1;
      tk(3);
      o_ale = 1'b0;
      tk(3);
    end
    o_data = d;
    o_data_oe = !rd;
    o_cs_n = 1'b0;
    o_rw = rd;
    o_ds_n = (sel != 2'h0);
    o_rd_n = !(rd && sel != 2'h0);
    o_wr_n = !(!rd && sel != 2'h0);
    tk(7);
    q = i_rdata;
    o_cs_n = 1'b1;
    o_ds_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_rw = 1'b1;
    tk(4);
    o_data_oe = 1'b0;
    tk(2);
  endtask
  task automatic acc(input logic rd, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    if (o_address_mode_select) begin
      cyc(1'b0, 8'h52, a, q);
      cyc(rd, 8'h53, d, q);
    end else begin
      cyc(rd, a, d, q);
    end
  endtask
endmodule
`default_nettype wire

// file: verification/hbi_top_sva.sv
// Port assertions for the host bus interface block.
`default_nettype none
module hbi_top_sva (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_ale,
  input wire logic i_cs_n,
  input wire logic i_terminal_mode,
  input wire logic o_data_oe,
  input wire logic o_irq_n_out,
  input wire logic o_irq_n_oe,
  input wire logic o_second_auxiliary_pin_out,
  input wire logic o_second_auxiliary_pin_oe,
  input wire logic o_dma_enable_a,
  input wire logic o_dma_enable_b,
  input wire logic [1:0] o_bus_type
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_arst_n);
  // The pin may only pull low, or the wire-OR with other sources breaks.
  a_irq_pull_low: assert property (o_irq_n_out == 1'b0)
    else $error("interrupt pin driven high");
  a_mux_edge: assert property (
    $changed(i_ale) |-> ##[1:6] o_bus_type == 2'h2)
    else $error("latch enable edge kept old bus");
  a_mux_stays: assert property (
    o_bus_type == 2'h2 |=> o_bus_type == 2'h2)
    else $error("left multiplexed bus");
  a_aux_line_off: assert property (
    !i_terminal_mode [*6] |-> !o_second_auxiliary_pin_oe)
    else $error("aux irq copy in line mode");
  a_dma_a_line: assert property (
    !i_terminal_mode [*6] |-> !o_dma_enable_a)
    else $error("channel A dma in line mode");
  a_dma_after_rst: assert property (
    $rose(i_arst_n) |-> (!o_dma_enable_a && !o_dma_enable_b) [*8])
    else $error("dma active after reset");
  a_oe_release: assert property (
    i_cs_n [*5] |-> !o_data_oe)
    else $error("data bus driven while deselected");
  a_oe_cause: assert property (
    $rose(o_data_oe) |-> !$past(i_cs_n, 3))
    else $error("data bus driven without select");
  a_aux_copy: assert property (
    o_second_auxiliary_pin_oe && $stable(o_irq_n_oe)
    |-> o_second_auxiliary_pin_out == o_irq_n_oe)
    else $error("aux irq copy differs");
endmodule
`default_nettype wire

// file: verification/test_host_bus_interface_irq.sv
// Self-checking bench for the host bus interface and its interrupt tree.
`include "hbi_defs.vh"
`default_nettype none
module test_host_bus_interface_irq;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, arst_n, term_mode, ale, cs_n, rw, ds_n, wr_n, rd_n, amsel, hoe;
  logic rdata_oe, irq_out, irq_oe, aux_out, aux_oe, dma_a, dma_b;
  logic [1:0] ext_irq, bus_type;
  logic [7:0] addr, hd, rdata, bus_d, q;
  logic [25:0] ev;
  int fails, total_checks, i, r;
  int bp [4] = '{12, 15, 19, 22};
  // Undriven bus shows the inverse of the last host byte, not a stale copy.
  assign bus_d = hoe ? hd : (rdata_oe ? rdata : ~hd);
  hbi_host host_u (.i_clock(clk), .i_rdata(bus_d), .o_ale(ale),
    .o_cs_n(cs_n), .o_rw(rw), .o_ds_n(ds_n), .o_wr_n(wr_n), .o_rd_n(rd_n),
    .o_address_mode_select(amsel), .o_addr(addr), .o_data(hd),
    .o_data_oe(hoe));
  hbi_top dut_u (.i_clock(clk), .i_arst_n(arst_n), .i_ale(ale),
    .i_cs_n(cs_n), .i_rw(rw), .i_ds_n(ds_n), .i_wr_n(wr_n), .i_rd_n(rd_n),
    .i_address_mode_select(amsel), .i_terminal_mode(term_mode),
    .i_addr(addr), .i_data(bus_d), .i_external_irq_inputs(ext_irq),
    .i_dchan_events(ev[7:0]), .i_dchan_ext_events(ev[11:8]),
    .i_bchan_a_events(ev[14:12]), .i_bchan_a_ext_events(ev[18:15]),
    .i_bchan_b_events(ev[21:19]), .i_bchan_b_ext_events(ev[25:22]),
    .o_data(rdata), .o_data_oe(rdata_oe), .o_irq_n_out(irq_out),
    .o_irq_n_oe(irq_oe), .o_second_auxiliary_pin_out(aux_out),
    .o_second_auxiliary_pin_oe(aux_oe), .o_dma_enable_a(dma_a),
    .o_dma_enable_b(dma_b), .o_bus_type(bus_type));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    host_u.acc(1'b1, a, 8'h00, d);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    host_u.acc(1'b0, a, d, x);
  endtask
  task automatic rst();
    arst_n = 1'b0;
    host_u.tk(16);
    arst_n = 1'b1;
    host_u.tk(10);
  endtask
  task automatic pulse(input logic [25:0] v);
    ev = v;
    host_u.tk(1);
    ev = 26'h0;
    host_u.tk(4);
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    stop_test();
  end
  initial begin
    arst_n = 1'b0;
    term_mode = 1'b1;
    ext_irq = 2'h0;
    ev = 26'h0;
    rst();
    chk("bus", bus_type, `HBI_BUS_MOTO);
    chk("dma_a", dma_a, 1'b0);
    chk("dma_b", dma_b, 1'b0);
    wr(8'h10, 8'h5A);
    wr(8'h11, 8'hA5);
    rd(8'h10, q);
    chk("mem", q, 8'h5A);
    wr(`HBI_A_CTRL, 8'h03);
    chk("dma_a", dma_a, 1'b1);
    chk("dma_b", dma_b, 1'b1);
    for (i = 0; i < 12; i++) begin
      pulse(26'h1 << i);
      chk("irq", irq_oe, 1'b1);
      rd(`HBI_A_TOP_ST, q);
      chk("top", q, i < 8 ? 8'h04 : 8'h08);
      rd(i < 8 ? `HBI_A_D_ST : `HBI_A_DX_ST, q);
      chk("dst", q, 8'h01 << (i % 8));
      chk("irq", irq_oe, 1'b0);
    end
    // Every B-channel event bit; bp holds the first bit of each register.
    for (i = 0; i < 14; i++) begin
      r = (i < 3) ? 0 : (i < 7) ? 1 : (i < 10) ? 2 : 3;
      pulse(26'h1 << (12 + i));
      chk("irq", irq_oe, 1'b1);
      rd(`HBI_A_TOP_ST, q);
      chk("top", q, 8'h10 << r);
      rd(8'h47 + 8'(2 * r), q);
      chk("bst", q, 8'h01 << (12 + i - bp[r]));
      chk("irq", irq_oe, 1'b0);
    end
    for (i = 0; i < 2; i++) begin
      ext_irq = 2'h1 << i;
      host_u.tk(6);
      chk("irq", irq_oe, 1'b1);
      rd(`HBI_A_TOP_ST, q);
      chk("top", q, 8'h01 << i);
      chk("irq", irq_oe, 1'b0);
    end
    ext_irq = 2'h0;
    wr(`HBI_A_D_MSK, 8'h01);
    pulse(26'h1);
    chk("irq", irq_oe, 1'b0);
    rd(`HBI_A_TOP_ST, q);
    chk("top", q, 8'h00);
    rd(`HBI_A_D_ST, q);
    chk("dst", q, 8'h01);
    wr(`HBI_A_D_MSK, 8'h00);
    wr(`HBI_A_TOP_MSK, 8'h04);
    pulse(26'h1);
    chk("irq", irq_oe, 1'b0);
    rd(`HBI_A_TOP_ST, q);
    chk("top", q, 8'h04);
    rd(`HBI_A_D_ST, q);
    chk("dst", q, 8'h01);
    wr(`HBI_A_TOP_MSK, 8'h00);
    wr(`HBI_A_CTRL, 8'h07);
    rd(`HBI_A_CTRL, q);
    chk("ctrl", q, 8'h07);
    chk("aux_oe", aux_oe, 1'b1);
    pulse(26'h1);
    chk("aux", aux_out, 1'b1);
    rd(`HBI_A_D_ST, q);
    chk("aux", aux_out, 1'b0);
    term_mode = 1'b0;
    host_u.tk(8);
    chk("aux_oe", aux_oe, 1'b0);
    chk("dma_a", dma_a, 1'b0);
    chk("dma_b", dma_b, 1'b1);
    term_mode = 1'b1;
    host_u.mode(2'h1, 1'b0);
    rst();
    chk("bus", bus_type, `HBI_BUS_SEP);
    host_u.mode(2'h1, 1'b1);
    wr(8'h21, 8'h3C);
    rd(8'h21, q);
    chk("ind", q, 8'h3C);
    host_u.mode(2'h1, 1'b0);
    rd(8'h21, q);
    chk("dir", q, 8'h3C);
    host_u.mode(2'h2, 1'b0);
    wr(8'h30, 8'h96);
    chk("bus", bus_type, `HBI_BUS_MUX);
    rd(8'h30, q);
    chk("mux", q, 8'h96);
    chk("bus", bus_type, `HBI_BUS_MUX);
    host_u.mode(2'h1, 1'b0);
    rst();
    chk("bus", bus_type, `HBI_BUS_SEP);
    stop_test();
  end
endmodule
bind hbi_top hbi_top_sva chk_u (.i_clock(i_clock), .i_arst_n(i_arst_n),
  .i_ale(i_ale), .i_cs_n(i_cs_n), .i_terminal_mode(i_terminal_mode),
  .o_data_oe(o_data_oe), .o_irq_n_out(o_irq_n_out), .o_irq_n_oe(o_irq_n_oe),
  .o_second_auxiliary_pin_out(o_second_auxiliary_pin_out),
  .o_second_auxiliary_pin_oe(o_second_auxiliary_pin_oe),
  .o_dma_enable_a(o_dma_enable_a), .o_dma_enable_b(o_dma_enable_b),
  .o_bus_type(o_bus_type));
`default_nettype wire
